// ==== dv/ebhg_master.sv ====
// model of the outside bus master that asks for the external bus
`timescale 1ns/100ps
module ebhg_master (
    input  wire clk,
    input  wire want,
    output reg  ext_bus_request_n
);
    reg want_q = 1'b0;
    initial ext_bus_request_n = 1'b1;
    // retime the wish so the pin never races the bench's own falling-edge writes
    always @(posedge clk) want_q <= want;
    always @(negedge clk) ext_bus_request_n <= !want_q;
endmodule

// ==== dv/ebhg_sva.sv ====
// concurrent checks on the ports of the hold and grant arbiter
`timescale 1ns/100ps
module ebhg_sva (
    input wire clk,
    input wire rst,
    input wire system_reset_n,
    input wire ext_bus_request_n,
    input wire half_rate,
    input wire cpu_ext_req,
    input wire cpu_ext_stall,
    input wire cpu_int_run,
    input wire hold_mode,
    input wire ext_bus_grant_n,
    input wire ext_addr_oe,
    input wire ext_data_oe,
    input wire ctrl_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_float_on_grant: assert property (!ext_bus_grant_n |-> !ext_addr_oe && !ext_data_oe && !ctrl_oe)
        else $error("bus driven while granted");
    a_req_latency: assert property ($fell(ext_bus_request_n) && ext_bus_grant_n && system_reset_n
        |-> (ext_bus_grant_n && ext_addr_oe) [*4]) else $error("request acted on before it was registered");
    a_float_full: assert property ($fell(ext_bus_request_n) && !half_rate && !hold_mode && !cpu_ext_req
        && ext_bus_grant_n |-> ##[1:10] !ext_addr_oe) else $error("bus not floated in time");
    a_grant_full: assert property ($fell(ext_bus_request_n) && !half_rate && !hold_mode && !cpu_ext_req
        && ext_bus_grant_n |-> ##[1:11] !ext_bus_grant_n) else $error("grant late at full rate");
    a_grant_half: assert property ($fell(ext_bus_request_n) && half_rate && !hold_mode && !cpu_ext_req
        && ext_bus_grant_n |-> ##[1:14] !ext_bus_grant_n) else $error("grant late at half rate");
    a_release_full: assert property ($rose(ext_bus_request_n) && !ext_bus_grant_n && !half_rate
        |-> ##[1:9] ext_bus_grant_n ##[0:1] ext_addr_oe) else $error("release late at full rate");
    a_release_half: assert property ($rose(ext_bus_request_n) && !ext_bus_grant_n && half_rate
        |-> ##[1:10] ext_bus_grant_n) else $error("release late at half rate");
    a_valid_half: assert property ($rose(ext_bus_request_n) && !ext_bus_grant_n && half_rate
        |-> ##[1:12] ext_addr_oe) else $error("bus not valid in time at half rate");
    a_mode_cleared: assert property (!system_reset_n [*5] |-> !hold_mode)
        else $error("hold mode survives system reset");
    a_internal_run: assert property (cpu_int_run)
        else $error("internal execution halted");
    a_stall_held: assert property (cpu_ext_req && $past(cpu_ext_req) && !ext_bus_grant_n
        && !$past(ext_bus_grant_n) && !ext_bus_request_n |-> cpu_ext_stall) else $error("access not stalled");
    a_mode_revoke: assert property ($rose(hold_mode) && !ext_bus_grant_n |-> ##[1:3] ext_bus_grant_n)
        else $error("grant kept after hold mode set");
    a_pending_first: assert property (cpu_ext_req && ext_addr_oe && system_reset_n |=> ext_addr_oe)
        else $error("bus floated over a pending access");
    c_grant_full: cover property (!half_rate && $fell(ext_bus_grant_n));
    c_grant_half: cover property (half_rate && $fell(ext_bus_grant_n));
    c_revoke: cover property ($rose(hold_mode) && !ext_bus_grant_n);
endmodule
bind ebhg_top ebhg_sva u_sva (.clk(clk), .rst(rst), .system_reset_n(system_reset_n),
    .ext_bus_request_n(ext_bus_request_n), .half_rate(half_rate), .cpu_ext_req(cpu_ext_req),
    .cpu_ext_stall(cpu_ext_stall), .cpu_int_run(cpu_int_run), .hold_mode(hold_mode),
    .ext_bus_grant_n(ext_bus_grant_n), .ext_addr_oe(ext_addr_oe), .ext_data_oe(ext_data_oe), .ctrl_oe(ctrl_oe));

// ==== dv/ebhg_top_tb.sv ====
// self-checking bench for the hold and grant arbiter
`timescale 1ns/100ps
`include "ebhg_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module ebhg_top_tb;
    reg                     clk = 0, rst = 1, system_reset_n = 0, half_rate = 0, hold_mode_wr = 0;
    reg                     hold_mode_wdata = 0, cpu_ext_req = 0, cpu_ext_we = 0, cpu_ext_hi = 0;
    reg                     ext_access_done = 0, want = 0, gprev = 1;
    reg [`EBHG_ADDR_W-1:0]  cpu_ext_addr = 20'h0_0000;
    reg [`EBHG_DATA_W-1:0]  cpu_ext_wdata = 32'h0000_0000;
    reg [2:0]               cpu_ext_zone = 3'h1;
    wire                    ext_bus_request_n, cpu_ext_stall, cpu_int_run, hold_mode, ext_bus_grant_n;
    wire                    ext_addr_oe, ext_data_oe;
    wire [`EBHG_ADDR_W-1:0] ext_addr_bus;
    wire                    ctrl_oe, read_strobe_n, interface_output_clock;
    integer                 seed = 51, miscompares = 0, n_checks = 0, i, k;
    reg                     gexp_q[$];
    ebhg_master u_master (.clk(clk), .want(want), .ext_bus_request_n(ext_bus_request_n));
    ebhg_top uut (.clk(clk), .rst(rst), .system_reset_n(system_reset_n), .ext_bus_request_n(ext_bus_request_n),
        .half_rate(half_rate), .hold_mode_wr(hold_mode_wr), .hold_mode_wdata(hold_mode_wdata),
        .cpu_ext_req(cpu_ext_req), .cpu_ext_we(cpu_ext_we), .cpu_ext_addr(cpu_ext_addr),
        .cpu_ext_wdata(cpu_ext_wdata), .cpu_ext_hi(cpu_ext_hi), .cpu_ext_zone(cpu_ext_zone),
        .ext_access_done(ext_access_done), .cpu_ext_stall(cpu_ext_stall), .cpu_int_run(cpu_int_run),
        .hold_mode(hold_mode), .ext_bus_grant_n(ext_bus_grant_n),
        .interface_output_clock(interface_output_clock), .ext_addr_bus(ext_addr_bus),
        .ext_addr_oe(ext_addr_oe), .ext_data_bus(), .ext_data_oe(ext_data_oe), .write_strobe_low_n(),
        .write_strobe_high_n(), .read_strobe_n(read_strobe_n), .read_not_write(), .zone_select_a_n(),
        .zone_select_b_n(), .zone_select_c_n(), .ctrl_oe(ctrl_oe));
    initial forever #2.5 clk = ~clk;
    task conclude;
        begin
            if (miscompares == 0 && n_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait on the grant pin; running out ends the run
    task wait_g(input reg v);
        begin
            for (k = 0; k < 60 && ext_bus_grant_n !== v; k++) cyc(1);
            if (k == 60) begin miscompares++; conclude; end
        end
    endtask
    task grant(input reg v);
        begin gexp_q.push_back(v); want = !v; wait_g(v); cyc(2); end
    endtask
    task wr_hold(input reg v);
        begin hold_mode_wdata = v; hold_mode_wr = 1; cyc(1); hold_mode_wr = 0; end
    endtask
    task access;
        begin
            cpu_ext_addr = $random(seed);
            cpu_ext_wdata = $random(seed);
            cpu_ext_we = $random(seed);
            cpu_ext_hi = $random(seed);
            cpu_ext_zone = 3'h1 << (($random(seed) & 3) % 3);
            cpu_ext_req = 1;
        end
    endtask
    task done_acc;
        begin ext_access_done = 1; cpu_ext_req = 0; cyc(1); ext_access_done = 0; end
    endtask
    // every grant transition must match the oldest expectation noted by the driver
    always @(negedge clk) if (!rst && ext_bus_grant_n !== gprev) begin
        gprev <= ext_bus_grant_n;
        if (gexp_q.size() == 0) `CHK("grant_n", gprev, ext_bus_grant_n)
        else `CHK("grant_n", gexp_q.pop_front(), ext_bus_grant_n)
    end
    initial begin
        cyc(16);
        rst = 0;
        cyc(6);
        `CHK("hold_mode", 1'b0, hold_mode)
        system_reset_n = 1;
        cyc(4);
        for (i = 0; i < 2; i++) begin
            half_rate = i;
            cyc(4);
            grant(0);
            `CHK("addr_oe", 1'b0, ext_addr_oe)
            `CHK("ctrl_oe", 1'b0, ctrl_oe)
            `CHK("int_run", 1'b1, cpu_int_run)
            k = interface_output_clock;
            cyc(1);
            `CHK("out_clk", half_rate ? !k[0] : 1'b1, interface_output_clock)
            access;
            cyc(4);
            `CHK("stall", 1'b1, cpu_ext_stall)
            grant(1);
            cyc(8);
            `CHK("addr_oe", 1'b1, ext_addr_oe)
            `CHK("addr_bus", cpu_ext_addr, ext_addr_bus)
            `CHK("rd_strobe", cpu_ext_we, read_strobe_n)
            done_acc;
            cyc(4);
        end
        half_rate = 0;
        access;
        cyc(2);
        want = 1;
        cyc(20);
        `CHK("addr_oe", 1'b1, ext_addr_oe)
        gexp_q.push_back(0);
        done_acc;
        wait_g(0);
        cyc(2);
        gexp_q.push_back(1);
        wr_hold(1);
        wait_g(1);
        cyc(8);
        `CHK("addr_oe", 1'b1, ext_addr_oe)
        want = 0;
        cyc(8);
        wr_hold(0);
        cyc(4);
        wr_hold(1);
        `CHK("hold_mode", 1'b1, hold_mode)
        gexp_q.push_back(0);
        want = 1;
        system_reset_n = 0;
        wait_g(0);
        `CHK("hold_mode", 1'b0, hold_mode)
        `CHK("data_oe", 1'b0, ext_data_oe)
        gexp_q.push_back(1);
        system_reset_n = 1;
        want = 0;
        wait_g(1);
        cyc(10);
        conclude;
    end
endmodule

// ==== shared/ebhg_defs.vh ====
// constants for the external bus hold and grant arbiter
`ifndef EBHG_DEFS_VH
`define EBHG_DEFS_VH
`define EBHG_ADDR_W          20
`define EBHG_DATA_W          32
`define EBHG_HOLD_MODE_RST   1'b0
`define EBHG_CLK_PERIOD_PS   5000
`define EBHG_SLACK_NS        30
`define EBHG_SLACK_CYC       ((`EBHG_SLACK_NS * 1000) / `EBHG_CLK_PERIOD_PS)
`define EBHG_FLOAT_TCYC      4
`define EBHG_GRANT_TCYC      5
`define EBHG_REL_FULL_TCYC   3
`define EBHG_BV_FULL_TCYC    4
`define EBHG_REL_HALF_TCYC   4
`define EBHG_BV_HALF_TCYC    6
`define EBHG_ST_NORMAL       3'h0
`define EBHG_ST_DRAIN        3'h1
`define EBHG_ST_FLOAT        3'h2
`define EBHG_ST_GRANTED      3'h3
`define EBHG_ST_RELEASE      3'h4
`endif

// ==== verilog/ebhg_clkdiv.v ====
// output clock phase: full rate or divided by two
`timescale 1ns/100ps
module ebhg_clkdiv (
    input  wire clk,
    input  wire rst,
    input  wire half_rate,
    output wire launch,
    output wire clk_out
);
    reg phase_r;
    always @(posedge clk or posedge rst) begin
        if (rst)
            phase_r <= 1'b0;
        else
            phase_r <= half_rate ? ~phase_r : 1'b0;
    end
    // launch marks the timing-clock edge that is a falling output-clock edge
    assign launch  = half_rate ? ~phase_r : 1'b1;
    assign clk_out = half_rate ? phase_r : 1'b1;
endmodule

// ==== verilog/ebhg_sync.v ====
// two-stage synchroniser for the hold request and system reset pins
`timescale 1ns/100ps
module ebhg_sync (
    input  wire clk,
    input  wire rst,
    input  wire din,
    output wire dout
);
    reg meta_r;
    reg sync_r;
    // both stages reset high so an idle request stays inactive
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end
    assign dout = sync_r;
endmodule

// ==== verilog/ebhg_top.v ====
// hold and grant arbiter for the external memory interface
`timescale 1ns/100ps
`include "ebhg_defs.vh"
// Summary of operation
// - setting hold mode while request and grant are both low drops the grant at cycle end and drives the pins again.
// - system reset clears the hold-mode bit.
// - a request held low through reset leaves the bus floated and the grant low.
// - the processor keeps running from internal memory while the grant is active.
// - a processor access to the external interface stalls while the grant is active until the request goes away.
// - on grant the address, data, both write strobes, read strobe, read/write line and three zone selects float.
// - every other interface signal keeps its normal behaviour during hold.
// - pending external accesses complete before the bus floats.
// - the hold request is registered on each rising timing-clock edge.
// - at half rate the float, drive and grant changes launch on falling output-clock edges, except those forced by system reset.
// - at full rate the bus floats within four cycles and the grant falls within five, each plus 30 ns.
// - at full rate the grant rises within three cycles and the bus is valid within four, each plus 30 ns.
// - at half rate the grant rises within four cycles and the bus is valid within six, each plus 30 ns.
module ebhg_top (
    input  wire                      clk,
    input  wire                      rst,
    input  wire                      system_reset_n,
    input  wire                      ext_bus_request_n,
    input  wire                      half_rate,
    input  wire                      hold_mode_wr,
    input  wire                      hold_mode_wdata,
    input  wire                      cpu_ext_req,
    input  wire                      cpu_ext_we,
    input  wire [`EBHG_ADDR_W-1:0]   cpu_ext_addr,
    input  wire [`EBHG_DATA_W-1:0]   cpu_ext_wdata,
    input  wire                      cpu_ext_hi,
    input  wire [2:0]                cpu_ext_zone,
    input  wire                      ext_access_done,
    output reg                       cpu_ext_stall,
    output reg                       cpu_int_run,
    output reg                       hold_mode,
    output reg                       ext_bus_grant_n,
    output reg                       interface_output_clock,
    output reg  [`EBHG_ADDR_W-1:0]   ext_addr_bus,
    output reg                       ext_addr_oe,
    output reg  [`EBHG_DATA_W-1:0]   ext_data_bus,
    output reg                       ext_data_oe,
    output reg                       write_strobe_low_n,
    output reg                       write_strobe_high_n,
    output reg                       read_strobe_n,
    output reg                       read_not_write,
    output reg                       zone_select_a_n,
    output reg                       zone_select_b_n,
    output reg                       zone_select_c_n,
    output reg                       ctrl_oe
);
    localparam ST_NORMAL  = `EBHG_ST_NORMAL;
    localparam ST_DRAIN   = `EBHG_ST_DRAIN;
    localparam ST_FLOAT   = `EBHG_ST_FLOAT;
    localparam ST_GRANTED = `EBHG_ST_GRANTED;
    localparam ST_RELEASE = `EBHG_ST_RELEASE;

    wire req_sync_n;
    wire launch;
    wire clk_div;
    wire sys_rst_sync_n;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg        req_q_r;
    reg        busy_r;
    reg        rst_seen_r;

    ebhg_sync u_req_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (ext_bus_request_n),
        .dout (req_sync_n)
    );

    ebhg_sync u_rst_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (system_reset_n),
        .dout (sys_rst_sync_n)
    );

    ebhg_clkdiv u_clkdiv (
        .clk       (clk),
        .rst       (rst),
        .half_rate (half_rate),
        .launch    (launch),
        .clk_out   (clk_div)
    );

    function is_floated;
        input [2:0] st;
        begin
            is_floated = (st == ST_FLOAT) || (st == ST_GRANTED);
        end
    endfunction

    // request registered every timing-clock edge after the pin synchroniser
    always @(posedge clk or posedge rst) begin
        if (rst)
            req_q_r <= 1'b0;
        else
            req_q_r <= ~req_sync_n;
    end

    // hold-mode bit: software write, cleared by system reset
    always @(posedge clk or posedge rst) begin
        if (rst)
            hold_mode <= `EBHG_HOLD_MODE_RST;
        else if (!sys_rst_sync_n)
            hold_mode <= `EBHG_HOLD_MODE_RST;
        else if (hold_mode_wr)
            hold_mode <= hold_mode_wdata;
    end

    // an access in flight is tracked so a hold waits for it
    // set only where the pins really launch an access, and a new launch wins over the done of the
    // previous one, otherwise the drain could float the bus over an access still on the pins
    always @(posedge clk or posedge rst) begin
        if (rst)
            busy_r <= 1'b0;
        else if (cpu_ext_req && !cpu_ext_stall && state_r == ST_NORMAL)
            busy_r <= 1'b1;
        else if (ext_access_done)
            busy_r <= 1'b0;
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            rst_seen_r <= 1'b0;
        else
            rst_seen_r <= ~sys_rst_sync_n;
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (req_q_r && !hold_mode)
                    state_nxt = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (!req_q_r)
                    state_nxt = ST_NORMAL;
                else if (!busy_r && !cpu_ext_req && launch)
                    state_nxt = ST_FLOAT;
            end
            ST_FLOAT: begin
                if (launch)
                    state_nxt = ST_GRANTED;
            end
            ST_GRANTED: begin
                if ((!req_q_r || hold_mode) && launch)
                    state_nxt = ST_RELEASE;
            end
            ST_RELEASE: begin
                if (launch)
                    state_nxt = ST_NORMAL;
            end
            default: state_nxt = ST_NORMAL;
        endcase
        // request held low during system reset forces the granted state
        if (!sys_rst_sync_n && req_q_r)
            state_nxt = ST_GRANTED;
        else if (!sys_rst_sync_n)
            state_nxt = ST_NORMAL;
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= ST_NORMAL;
        else
            state_r <= state_nxt;
    end

    // pin drivers: registered, address and control enables drop only in floated states; data enable only drives during a write in flight
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_bus_grant_n        <= 1'b1;
            ext_addr_oe            <= 1'b1;
            ext_data_oe            <= 1'b0;
            ctrl_oe                <= 1'b1;
            cpu_ext_stall          <= 1'b0;
            cpu_int_run            <= 1'b1;
            interface_output_clock <= 1'b0;
            ext_addr_bus           <= {`EBHG_ADDR_W{1'b0}};
            ext_data_bus           <= {`EBHG_DATA_W{1'b0}};
            write_strobe_low_n     <= 1'b1;
            write_strobe_high_n    <= 1'b1;
            read_strobe_n          <= 1'b1;
            read_not_write         <= 1'b1;
            zone_select_a_n        <= 1'b1;
            zone_select_b_n        <= 1'b1;
            zone_select_c_n        <= 1'b1;
        end else begin
            ext_bus_grant_n        <= ~(state_nxt == ST_GRANTED);
            ext_addr_oe            <= ~is_floated(state_nxt);
            ctrl_oe                <= ~is_floated(state_nxt);
            ext_data_oe            <= ~is_floated(state_nxt) && busy_r && cpu_ext_we;
            // stall new external accesses while draining or held
            cpu_ext_stall          <= cpu_ext_req && (state_nxt != ST_NORMAL);
            cpu_int_run            <= 1'b1;
            // the output clock keeps running through a hold
            interface_output_clock <= clk_div;
            if (cpu_ext_req && !cpu_ext_stall && state_r == ST_NORMAL) begin
                ext_addr_bus        <= cpu_ext_addr;
                ext_data_bus        <= cpu_ext_wdata;
                read_not_write      <= ~cpu_ext_we;
                write_strobe_low_n  <= ~cpu_ext_we;
                write_strobe_high_n <= ~(cpu_ext_we && cpu_ext_hi);
                read_strobe_n       <= cpu_ext_we;
                zone_select_a_n     <= ~cpu_ext_zone[0];
                zone_select_b_n     <= ~cpu_ext_zone[1];
                zone_select_c_n     <= ~cpu_ext_zone[2];
            end else if (ext_access_done || !busy_r) begin
                // strobes go inactive; address holds its last value
                write_strobe_low_n  <= 1'b1;
                write_strobe_high_n <= 1'b1;
                read_strobe_n       <= 1'b1;
                read_not_write      <= 1'b1;
                zone_select_a_n     <= 1'b1;
                zone_select_b_n     <= 1'b1;
                zone_select_c_n     <= 1'b1;
            end
        end
    end
endmodule
